/* src/gvl_pkg.sv */
/*
 * constants for the gpio output-value and level-shift block: register
 * offsets, field positions and values after reset.
 * assumes an 8-bit register address space reached by byte accesses.
 */
package gvl_pkg;

    // =========================================================
    // register port shape
    localparam int ADDR_W = 8;                       // register address width
    localparam int DATA_W = 8;                       // register data width
    localparam int PAIRS  = 8;                       // lower/upper pin pairs
    localparam int PINS   = 2 * PAIRS;               // all gpio pins

    // =========================================================
    // register offsets
    localparam logic [7:0] OFF_DIR_LO    = 8'h34;    // lower pin direction
    localparam logic [7:0] OFF_DIR_HI    = 8'h35;    // upper pin direction
    localparam logic [7:0] OFF_MODE_LO   = 8'h36;    // lower output mode
    localparam logic [7:0] OFF_MODE_HI   = 8'h37;    // upper output mode
    localparam logic [7:0] OFF_VAL_LO    = 8'h3A;    // lower_output_values
    localparam logic [7:0] OFF_VAL_HI    = 8'h3B;    // upper_output_values
    localparam logic [7:0] OFF_SHIFT     = 8'h3C;    // pair_translation_enable
    localparam logic [7:0] OFF_GLOBAL    = 8'h40;    // global configuration

    // =========================================================
    // fields
    localparam int         BIT_GPIO_EN   = 4;        // global gpio enable
    localparam int         BIT_GPIO_RST  = 3;        // momentary gpio reset
    localparam logic [7:0] GLOBAL_MASK   = 8'h37;    // stored global bits
    localparam logic [7:0] OD_ONLY_HI    = 8'hF0;    // pins 12-15 fixed open-drain

    // =========================================================
    // values after reset
    localparam logic [7:0] RST_DIR       = 8'h00;    // all pins inputs
    localparam logic [7:0] RST_MODE_LO   = 8'hFF;    // lower pins push-pull
    localparam logic [7:0] RST_MODE_HI   = 8'h00;    // upper pins open-drain
    localparam logic [7:0] RST_VAL       = 8'hFF;    // outputs high
    localparam logic [7:0] RST_SHIFT     = 8'h00;    // no pair connected
    localparam logic [7:0] RST_GLOBAL    = 8'h00;    // gpio disabled
    localparam logic [7:0] RD_UNMAPPED   = 8'h00;    // answer to unmapped reads

endpackage

/* src/gvl_pin_cell.sv */
/*
 * one pin driver: turns drive request, level and open-drain choice into
 * the pin output and its active-low output enable.
 * assumes the caller registers the results.
 */
`timescale 1ns/10ps
`default_nettype none

module gvl_pin_cell (
    input  wire logic drive,      // pin acts as output
    input  wire logic level,      // wanted pin level
    input  wire logic openDrain,  // high level is a release
    output logic      pinOut,     // level to put on the pin
    output logic      pinOeN      // low while the pin is driven
);

    // =========================================================
    // driver decision
    always_comb begin
        if (!drive) begin
            // input: release
            pinOut = 1'b0;
            pinOeN = 1'b1;
        end else if (openDrain && level) begin
            // open-drain high: release, pullup pulls high
            pinOut = 1'b0;
            pinOeN = 1'b1;
        end else begin
            // push-pull, or open-drain low
            pinOut = level;
            pinOeN = 1'b0;
        end
    end

endmodule

`default_nettype wire

/* src/gvl_gpio_out_shift.sv */
/*
 * gpio output values and pair level translation for a 16-pin expander.
 * assumes the serial bus slave sits on the same clock and gives one-cycle
 * byte read and write strobes; pins are asynchronous and are synchronised.
 */
`timescale 1ns/10ps
`default_nettype none

module gvl_gpio_out_shift (
    input  wire logic                       clk,        // 100 MHz clock
    input  wire logic                       nrst,       // async reset, active low
    input  wire logic                       regWrEn,    // byte write strobe
    input  wire logic                       regRdEn,    // byte read strobe
    input  wire logic [gvl_pkg::ADDR_W-1:0] regAddr,    // register offset
    input  wire logic [gvl_pkg::DATA_W-1:0] regWrData,  // write byte
    output logic      [gvl_pkg::DATA_W-1:0] regRdData,  // read byte
    output logic                            regRdValid, // read answer pulse
    input  wire logic [gvl_pkg::PINS-1:0]   pinIn,      // pin levels seen
    output logic      [gvl_pkg::PINS-1:0]   pinOut,     // pin drive levels
    output logic      [gvl_pkg::PINS-1:0]   pinOeN      // low while driven
);
    import gvl_pkg::*;

    // =========================================================
    // state
    logic [7:0]      dirLo_q;       // lower direction, 1 = output
    logic [7:0]      dirHi_q;       // upper direction, also pair direction
    logic [7:0]      modeLo_q;      // lower mode, 1 = push-pull
    logic [7:0]      modeHi_q;      // upper mode, 1 = push-pull
    logic [7:0]      valLo_q;       // lower output values
    logic [7:0]      valHi_q;       // upper output values
    logic [7:0]      shift_q;       // pair translation enables
    logic [7:0]      global_q;      // global configuration
    logic [PINS-1:0] pinMeta_q;     // first sync stage
    logic [PINS-1:0] pinSync_q;     // second sync stage
    logic [PINS-1:0] pinOut_q;      // registered pin levels
    logic [PINS-1:0] pinOeN_q;      // registered enables
    logic [7:0]      rdData_q;      // read answer
    logic            rdValid_q;     // read answer strobe
    logic            gpioEn;        // gpio enabled
    logic            cfgReset;      // write of the reset bit
    logic            wrOk;          // accepted configuration write
    logic [PINS-1:0] cellDrive;     // per pin drive request
    logic [PINS-1:0] cellLevel;     // per pin wanted level
    logic [PINS-1:0] cellOd;        // per pin open-drain
    logic [PINS-1:0] cellOut;       // cell pin level
    logic [PINS-1:0] cellOeN;       // cell enable

    // register contents as seen by a read
    function automatic logic [7:0] readMux(input logic [7:0] a);
        unique case (a)
            OFF_DIR_LO:  readMux = dirLo_q;
            OFF_DIR_HI:  readMux = dirHi_q;
            OFF_MODE_LO: readMux = modeLo_q;
            OFF_MODE_HI: readMux = modeHi_q;
            OFF_VAL_LO:  readMux = valLo_q;
            OFF_VAL_HI:  readMux = valHi_q;
            OFF_SHIFT:   readMux = shift_q;
            OFF_GLOBAL:  readMux = global_q;
            default:     readMux = RD_UNMAPPED;
        endcase
    endfunction

    // =========================================================
    // write qualification
    assign gpioEn   = global_q[BIT_GPIO_EN];
    assign cfgReset = regWrEn && (regAddr == OFF_GLOBAL) && regWrData[BIT_GPIO_RST];
    // global register stays writable, otherwise nothing could enable gpio
    assign wrOk     = regWrEn && gpioEn && (regAddr != OFF_GLOBAL);

    // =========================================================
    // global configuration; reset bit is never stored
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            global_q <= RST_GLOBAL;
        end else if (regWrEn && (regAddr == OFF_GLOBAL)) begin
            global_q <= regWrData & GLOBAL_MASK;
        end
    end

    // =========================================================
    // configuration registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dirLo_q  <= RST_DIR;
            dirHi_q  <= RST_DIR;
            modeLo_q <= RST_MODE_LO;
            modeHi_q <= RST_MODE_HI;
            valLo_q  <= RST_VAL;
            valHi_q  <= RST_VAL;
            shift_q  <= RST_SHIFT;
        end else if (cfgReset) begin
            // momentary reset back to power-on values
            dirLo_q  <= RST_DIR;
            dirHi_q  <= RST_DIR;
            modeLo_q <= RST_MODE_LO;
            modeHi_q <= RST_MODE_HI;
            valLo_q  <= RST_VAL;
            valHi_q  <= RST_VAL;
            shift_q  <= RST_SHIFT;
        end else if (wrOk) begin
            // byte write by offset; unmapped offsets are ignored
            case (regAddr)
                OFF_DIR_LO:  dirLo_q  <= regWrData;
                OFF_DIR_HI:  dirHi_q  <= regWrData;
                OFF_MODE_LO: modeLo_q <= regWrData;
                OFF_MODE_HI: modeHi_q <= regWrData & ~OD_ONLY_HI;
                OFF_VAL_LO:  valLo_q  <= regWrData;
                OFF_VAL_HI:  valHi_q  <= regWrData;
                OFF_SHIFT:   shift_q  <= regWrData;
                default:     ;
            endcase
        end
    end

    // =========================================================
    // read answer, one cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdData_q  <= RD_UNMAPPED;
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= regRdEn;
            if (regRdEn) begin
                rdData_q <= readMux(regAddr);
            end
        end
    end

    // =========================================================
    // pin synchroniser
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pinMeta_q <= '0;
            pinSync_q <= '0;
        end else begin
            pinMeta_q <= pinIn;
            pinSync_q <= pinMeta_q;
        end
    end

    // =========================================================
    // per pair: plain outputs or level translation
    always_comb begin
        cellDrive = '0;
        cellLevel = '0;
        cellOd    = '0;
        for (int n = 0; n < PAIRS; n++) begin
            cellOd[n]       = !modeLo_q[n];
            cellOd[n+PAIRS] = !modeHi_q[n] || OD_ONLY_HI[n];
            if (shift_q[n]) begin
                // translating pair; upper direction picks the way
                if (dirHi_q[n]) begin
                    cellDrive[n+PAIRS] = 1'b1;
                    cellLevel[n+PAIRS] = pinSync_q[n];
                end else begin
                    cellDrive[n] = 1'b1;
                    cellLevel[n] = pinSync_q[n+PAIRS];
                end
            end else begin
                // pair unconnected: value registers drive outputs
                cellDrive[n]       = dirLo_q[n];
                cellLevel[n]       = valLo_q[n];
                cellDrive[n+PAIRS] = dirHi_q[n];
                cellLevel[n+PAIRS] = valHi_q[n];
            end
        end
    end

    // one driver cell per pin
    for (genvar p = 0; p < PINS; p++) begin : gPin
        gvl_pin_cell uCell (
            .drive     (cellDrive[p]),
            .level     (cellLevel[p]),
            .openDrain (cellOd[p]),
            .pinOut    (cellOut[p]),
            .pinOeN    (cellOeN[p])
        );
    end

    // pins come from flip-flops, released during reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pinOut_q <= '0;
            pinOeN_q <= '1;
        end else begin
            pinOut_q <= cellOut;
            pinOeN_q <= cellOeN;
        end
    end

    assign pinOut     = pinOut_q;
    assign pinOeN     = pinOeN_q;
    assign regRdData  = rdData_q;
    assign regRdValid = rdValid_q;

    // =========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_lower_write: assert property (wrOk && regAddr == OFF_VAL_LO |=>
        valLo_q == $past(regWrData)) else $error("lower value write lost");
    a_upper_write: assert property (wrOk && regAddr == OFF_VAL_HI |=>
        valHi_q == $past(regWrData)) else $error("upper value write lost");
    a_od_release: assert property (dirHi_q[7] && !shift_q[7] && valHi_q[7] |=>
        pinOeN_q[15]) else $error("pin 15 driven high");
    a_pair_off: assert property (!shift_q[0] && dirLo_q[0] && modeLo_q[0] |=>
        !pinOeN_q[0] && pinOut_q[0] == $past(valLo_q[0])) else $error("pin 0 not from value");
    a_pair_dir: assert property (shift_q[0] && !dirHi_q[0] && modeLo_q[0] |=>
        !pinOeN_q[0] && pinOut_q[0] == $past(pinSync_q[8])) else $error("pair 0 wrong way");
    a_locked_hold: assert property (regWrEn && !gpioEn && regAddr == OFF_VAL_LO |=>
        $stable(valLo_q)) else $error("write taken while disabled");
    a_reset_values: assert property (cfgReset |=>
        valLo_q == RST_VAL && shift_q == RST_SHIFT && !global_q[BIT_GPIO_RST])
        else $error("gpio reset incomplete");
    a_od_fixed: assert property ((modeHi_q & OD_ONLY_HI) == 8'h00)
        else $error("upper mode bits writable");
    a_read_shift: assert property (regRdEn && regAddr == OFF_SHIFT |=>
        regRdValid && regRdData == $past(shift_q)) else $error("shift read wrong");

endmodule

`default_nettype wire

/* tb/gvl_pin_world.sv */
/*
 * pin world model: resolves each gpio wire from the block drive,
 * external drivers and the pullups on pins 12-15.
 * assumes pinOeN low means the block drives the pin.
 */
`timescale 1ns/10ps
`default_nettype none

module gvl_pin_world (
    input  wire logic [15:0] pinOut,   // block drive level
    input  wire logic [15:0] pinOeN,   // low while block drives
    input  wire logic [15:0] extDrive, // external driver active
    input  wire logic [15:0] extLevel, // external driver level
    output logic      [15:0] wireLvl   // resolved pin level
);
    // ========
    // wire resolution, block drive wins
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (!pinOeN[i]) begin
                wireLvl[i] = pinOut[i];   // block drives
            end else if (extDrive[i]) begin
                wireLvl[i] = extLevel[i]; // far side drives a released pin
            end else if (i >= 12) begin
                wireLvl[i] = 1'b1;        // external pullup
            end else begin
                wireLvl[i] = ~pinOut[i];  // floating: ~pinOut, always high as a released pin has pinOut 0
            end
        end
    end
endmodule
`default_nettype wire

/* tb/gvl_gpio_out_shift_test.sv */
/*
 * self-checking bench: register access, pin values, pair translation.
 * assumes the pin world model resolves the wires fed back to pinIn.
 */
`timescale 1ns/10ps
`default_nettype none

module gvl_gpio_out_shift_test;
    import gvl_pkg::*;
    logic        clk, nrst, regWrEn, regRdEn, regRdValid; // bench drive
    logic [7:0]  regAddr, regWrData, regRdData;           // register port
    logic [15:0] pinIn, pinOut, pinOeN, extDrive, extLevel; // pins
    logic [31:0] seed;                                    // xorshift state
    logic [7:0]  vLo, vHi, sh, dh;                        // picked values
    logic [15:0] m;                                       // source pins
    int          nErrors, samplesChecked;                 // tallies

    gvl_gpio_out_shift i_dut (.clk(clk), .nrst(nrst), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .regRdValid(regRdValid), .pinIn(pinIn),
        .pinOut(pinOut), .pinOeN(pinOeN));
    gvl_pin_world i_world (.pinOut(pinOut), .pinOeN(pinOeN),
        .extDrive(extDrive), .extLevel(extLevel), .wireLvl(pinIn));

    // ========
    // helpers
    always #5 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // expected wire levels: values, or the partner of each joined pair
    function automatic logic [15:0] expWire(input logic [7:0] lo, hi, j, d,
                                            input logic [15:0] ext);
        logic [15:0] e;
        e = {hi, lo};
        for (int n = 0; n < 8; n++) begin
            if (j[n]) begin
                e[n]     = d[n] ? ext[n] : ext[n+8];
                e[n + 8] = e[n];
            end
        end
        return e;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regWrEn   = 1'b1;
        regAddr   = a;
        regWrData = d;
        @(negedge clk);
        regWrEn = 1'b0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        regRdEn = 1'b1;
        regAddr = a;
        @(negedge clk);
        regRdEn = 1'b0;
        chk({15'h0, regRdValid}, 16'h0001);
        chk({8'h00, regRdData}, {8'h00, exp});
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ========
    // watchdog
    initial begin
        #100000;
        nErrors++;
        tally_and_finish();
    end

    // ========
    // main sequence
    initial begin
        {clk, nrst, regWrEn, regRdEn, regAddr, regWrData} = '0;
        {extDrive, extLevel, nErrors, samplesChecked} = '0;
        seed = 32'hB28B5788;
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        chk(pinOeN, 16'hFFFF);
        rdChk(OFF_SHIFT, RST_SHIFT);
        wrReg(OFF_VAL_LO, 8'h00);
        rdChk(OFF_VAL_LO, RST_VAL);
        $display("test reset and disabled writes done");
        wrReg(OFF_GLOBAL, 8'h10);
        wrReg(OFF_DIR_LO, 8'hFF);
        wrReg(OFF_MODE_LO, 8'hFF);
        wrReg(OFF_MODE_HI, 8'hFF);
        rdChk(OFF_MODE_HI, 8'h0F);
        for (int k = 0; k < 40; k++) begin
            seed = xs(seed);
            {dh, sh, vHi, vLo} = seed;
            sh = (k < 10) ? 8'h00 : (k == 10) ? 8'hFF : sh;
            dh = (k == 10) ? 8'h00 : (k == 11) ? 8'hFF : dh | ~sh;
            seed = xs(seed);
            m = '0;
            for (int n = 0; n < 8; n++) begin
                m[dh[n] ? n : n + 8] = sh[n];
            end
            wrReg(OFF_VAL_LO, vLo);
            wrReg(OFF_VAL_HI, vHi);
            wrReg(OFF_DIR_HI, dh);
            wrReg(OFF_SHIFT, sh);
            extDrive = m;
            extLevel = seed[15:0];
            repeat (6) @(negedge clk);
            chk(pinIn, expWire(vLo, vHi, sh, dh, seed[15:0]));
            chk(pinOeN & m, m);
            if (sh == 8'h00) begin
                chk(pinOeN, {vHi[7:4], 12'h000});
            end
            rdChk(OFF_VAL_HI, vHi);
        end
        $display("test values and translation done");
        extDrive = '0;
        // lower pins open-drain: a high value releases, a low value drives
        wrReg(OFF_SHIFT, 8'h00);
        wrReg(OFF_MODE_LO, 8'h00);
        wrReg(OFF_VAL_LO, 8'hA5);
        repeat (2) @(negedge clk);
        chk({8'h00, pinOeN[7:0]}, 16'h00A5);
        // disabled again: writes refused, outputs keep running
        wrReg(OFF_GLOBAL, 8'h00);
        wrReg(OFF_SHIFT, 8'hFF);
        rdChk(OFF_SHIFT, RST_SHIFT);
        chk({8'h00, pinOeN[7:0]}, 16'h00A5);
        $display("test open-drain and lock done");
        // soft reset works while disabled and enables through the same write
        wrReg(OFF_GLOBAL, 8'h18);
        rdChk(OFF_GLOBAL, 8'h10);
        rdChk(OFF_VAL_LO, RST_VAL);
        rdChk(OFF_SHIFT, RST_SHIFT);
        rdChk(OFF_DIR_HI, RST_DIR);
        chk(pinOeN, 16'hFFFF);
        rdChk(8'h50, RD_UNMAPPED);
        $display("test soft reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
